/* File: core/exec_core.sv */
// Execution unit for six core instructions, with PC, return stack,
// work register, zero flag, interrupt enable and table-high pointer.
// Assumes instructions arrive one per cycle from same-clock fetch logic.
//
// Contract
// - irq_on_op sets global_irq_enable, one cycle, flags untouched.
// - jump_via_acc_op loads PC from table_high_pointer[1:0] and work_reg.
// - jump_via_acc_op is unconditional and takes two cycles.
// - add_one_op increments register, routes by dest_select, updates zero, one cycle.
// - soft_trap_op pushes PC+1, loads PC with 0x001, three cycles.
// - add_one_skip_zero_op increments register, routes result by dest_select.
// - Zero result discards fetched next instruction; takes two cycles.
//
// The address map and the address-and-strobe port are this design's own decisions.
`default_nettype none
module exec_core #(
    parameter int STACK_DEPTH = 4
) (
    input wire logic mclk, // Instruction clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic instr_valid, // Instruction presented this cycle
    input wire exec_pkg::instr_t instr, // Decoded instruction
    input wire exec_pkg::reg_req_t reg_req, // Software register access
    output logic [exec_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after
    output logic ready, // Accepts an instruction
    output logic skip_pulse, // Fetched instruction being discarded
    output logic [exec_pkg::PC_W-1:0] pc, // Program counter
    output logic [exec_pkg::DATA_W-1:0] work_reg, // Accumulator
    output logic zero_flag, // Zero status
    output logic global_irq_enable, // Interrupt enable
    output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr // Return stack pointer
);
    import exec_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    exec_state_t state_r, state_nxt;
    logic [PC_W-1:0] pc_r;
    logic [DATA_W-1:0] work_r;
    logic zero_r, irq_en_r, ready_r, skip_r;
    logic [TAB_HI_W-1:0] tab_hi_r;
    logic [SP_W-1:0] sp_r;
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] fdata, result;
    logic accept, writes_data, file_we, res_zero;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == BYTE_ZERO;
    endfunction : is_zero

    file_regs u_file (
        .mclk(mclk),
        .addr(instr.faddr),
        .we(file_we),
        .wdata(result),
        .rdata(fdata)
    );

    assign accept = instr_valid && ready_r;

    // Arithmetic result; 8-bit add wraps 0xff to zero
    always_comb begin
        result = BYTE_ZERO;
        writes_data = 1'b0;
        unique case (instr.op)
            OP_ADD_ONE, OP_ADD_ONE_SKIP: begin
                result = fdata + BYTE_ONE;
                writes_data = 1'b1;
            end
            OP_OR_WORK: begin
                result = work_r | fdata;
                writes_data = 1'b1;
            end
            default: begin
                result = BYTE_ZERO;
            end
        endcase
    end

    assign res_zero = is_zero(result);
    assign file_we = accept && writes_data && (instr.dest == DEST_FILE);

    // Sequencer: extra cycles for branch, trap and taken skip
    always_comb begin
        state_nxt = ST_RUN;
        unique case (state_r)
            ST_RUN: begin
                if (accept && instr.op == OP_JUMP_WORK) begin
                    state_nxt = ST_WAIT_LAST;
                end else if (accept && instr.op == OP_SOFT_TRAP) begin
                    state_nxt = ST_WAIT_A;
                end else if (accept && instr.op == OP_ADD_ONE_SKIP && res_zero) begin
                    state_nxt = ST_WAIT_LAST;
                end
            end
            ST_WAIT_A: state_nxt = ST_WAIT_LAST;
            ST_WAIT_LAST: state_nxt = ST_RUN;
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_RUN;
            ready_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            ready_r <= (state_nxt == ST_RUN);
        end
    end

    // Pulse marks the cycle whose fetched instruction is thrown away
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            skip_r <= 1'b0;
        end else begin
            skip_r <= accept && instr.op == OP_ADD_ONE_SKIP && res_zero;
        end
    end

    // Program counter; a taken skip steps over the discarded slot
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc_r <= PC_RESET;
        end else if (accept) begin
            unique case (instr.op)
                OP_JUMP_WORK: pc_r <= {tab_hi_r, work_r};
                OP_SOFT_TRAP: pc_r <= TRAP_VECTOR;
                OP_ADD_ONE_SKIP: pc_r <= pc_r + (res_zero ? PC_SKIP_STEP : PC_STEP);
                default: pc_r <= pc_r + PC_STEP;
            endcase
        end
    end

    // Return stack; overflow wraps and overwrites the oldest entry
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sp_r <= '0;
        end else if (accept && instr.op == OP_SOFT_TRAP) begin
            sp_r <= sp_r + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (accept && instr.op == OP_SOFT_TRAP) begin
            stack_r[sp_r] <= pc_r + PC_STEP;
        end
    end

    // Work register; software write loses to an executing instruction
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            work_r <= BYTE_ZERO;
        end else if (accept && writes_data && instr.dest == DEST_WORK) begin
            work_r <= result;
        end else if (reg_req.we && reg_req.addr == REG_WORK) begin
            work_r <= reg_req.wdata;
        end
    end

    // Zero flag; skip variant leaves it alone
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            zero_r <= 1'b0;
        end else if (accept && (instr.op == OP_ADD_ONE || instr.op == OP_OR_WORK)) begin
            zero_r <= res_zero;
        end
    end

    // Interrupt enable; the instruction's set wins over a software clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_en_r <= 1'b0;
        end else if (accept && instr.op == OP_IRQ_ON) begin
            irq_en_r <= 1'b1;
        end else if (reg_req.we && reg_req.addr == REG_CTRL) begin
            irq_en_r <= reg_req.wdata[CTRL_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tab_hi_r <= '0;
        end else if (reg_req.we && reg_req.addr == REG_CTRL) begin
            tab_hi_r <= reg_req.wdata[CTRL_TAB_HI_LSB +: TAB_HI_W];
        end
    end

    // Register read; unmapped index reads zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= BYTE_ZERO;
        end else if (reg_req.re) begin
            rdata_r <= BYTE_ZERO;
            unique case (reg_req.addr)
                REG_CTRL: begin
                    rdata_r[CTRL_IRQ_EN_BIT] <= irq_en_r;
                    rdata_r[CTRL_TAB_HI_LSB +: TAB_HI_W] <= tab_hi_r;
                end
                REG_STATUS: begin
                    rdata_r[STAT_ZERO_BIT] <= zero_r;
                    rdata_r[STAT_READY_BIT] <= ready_r;
                end
                REG_WORK: rdata_r <= work_r;
                default: rdata_r <= BYTE_ZERO;
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign ready = ready_r;
    assign skip_pulse = skip_r;
    assign pc = pc_r;
    assign work_reg = work_r;
    assign zero_flag = zero_r;
    assign global_irq_enable = irq_en_r;
    assign stack_ptr = sp_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_irq_on_sets: assert property (accept && instr.op == OP_IRQ_ON
        |=> irq_en_r && ready_r && $stable(zero_r)) else $error("irq enable not set");
    a_jump_target: assert property (accept && instr.op == OP_JUMP_WORK
        |=> pc_r == {$past(tab_hi_r), $past(work_r)}) else $error("jump target wrong");
    a_jump_cycles: assert property (accept && instr.op == OP_JUMP_WORK
        |=> !ready_r ##1 ready_r) else $error("jump not two cycles");
    a_inc_zero: assert property (accept && instr.op == OP_ADD_ONE
        |=> zero_r == ($past(fdata) == 8'hff)) else $error("increment zero flag wrong");
    a_trap_vector: assert property (accept && instr.op == OP_SOFT_TRAP
        |=> pc_r == TRAP_VECTOR && stack_r[$past(sp_r)] == $past(pc_r) + PC_STEP)
        else $error("trap push or vector wrong");
    a_trap_cycles: assert property (accept && instr.op == OP_SOFT_TRAP
        |=> !ready_r [*2] ##1 ready_r) else $error("trap not three cycles");
    a_skip_work: assert property (accept && instr.op == OP_ADD_ONE_SKIP
        && instr.dest == DEST_WORK |=> work_r == $past(fdata) + BYTE_ONE)
        else $error("skip increment result wrong");
    a_skip_taken: assert property (accept && instr.op == OP_ADD_ONE_SKIP && res_zero
        |=> skip_r && !ready_r ##1 ready_r) else $error("skip not two cycles");
    a_skip_none: assert property (accept && instr.op == OP_ADD_ONE_SKIP && !res_zero
        |=> ready_r && !skip_r) else $error("skip taken wrongly");
    a_or_result: assert property (accept && instr.op == OP_OR_WORK && instr.dest == DEST_WORK
        |=> work_r == ($past(work_r) | $past(fdata)) && zero_r == (work_r == BYTE_ZERO))
        else $error("or result wrong");

    c_jump: cover property (accept && instr.op == OP_JUMP_WORK ##2 accept);
    c_trap: cover property (accept && instr.op == OP_SOFT_TRAP ##3 accept);
    c_skip: cover property (accept && instr.op == OP_ADD_ONE_SKIP && res_zero);
    c_wrap: cover property (accept && instr.op == OP_ADD_ONE && res_zero);
endmodule : exec_core
`default_nettype wire

/* File: core/exec_pkg.sv */
// Shared types and constants for the instruction execution subset.
// Assumes a single instruction clock with one instruction per cycle.
`default_nettype none
package exec_pkg;
    localparam int PC_W = 10;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 6;
    localparam int TAB_HI_W = 2;
    localparam int REG_ADDR_W = 2;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam logic [PC_W-1:0] TRAP_VECTOR = 10'h001;
    localparam logic [PC_W-1:0] PC_STEP = 10'h001;
    localparam logic [PC_W-1:0] PC_SKIP_STEP = 10'h002;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic DEST_WORK = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    // Register port map: word indices
    localparam logic [REG_ADDR_W-1:0] REG_CTRL = 2'h0;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 2'h1;
    localparam logic [REG_ADDR_W-1:0] REG_WORK = 2'h2;
    // Field positions
    localparam int CTRL_IRQ_EN_BIT = 0;
    localparam int CTRL_TAB_HI_LSB = 1;
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_READY_BIT = 1;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_IRQ_ON = 3'h1,
        OP_JUMP_WORK = 3'h2,
        OP_ADD_ONE = 3'h3,
        OP_ADD_ONE_SKIP = 3'h4,
        OP_SOFT_TRAP = 3'h5,
        OP_OR_WORK = 3'h6
    } op_t;

    typedef struct packed {
        op_t op;
        logic [FADDR_W-1:0] faddr;
        logic dest;
    } instr_t;

    typedef struct packed {
        logic [REG_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WAIT_A = 2'b01,
        ST_WAIT_LAST = 2'b11
    } exec_state_t;
endpackage : exec_pkg
`default_nettype wire

/* File: core/file_regs.sv */
// General purpose file register array, 64 bytes.
// Assumes the same clock as the executing core; read is combinational.
`default_nettype none
module file_regs #(
    parameter int DEPTH = 64
) (
    input wire logic mclk, // Instruction clock
    input wire logic [exec_pkg::FADDR_W-1:0] addr, // Register address
    input wire logic we, // Write strobe
    input wire logic [exec_pkg::DATA_W-1:0] wdata, // Write data
    output logic [exec_pkg::DATA_W-1:0] rdata // Read data, same cycle
);
    import exec_pkg::*;

    logic [DATA_W-1:0] mem [DEPTH];

    // No reset: contents are undefined until an instruction writes them
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule : file_regs
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the execution unit: a behavioural model of pc,
// work_reg, flags, stack pointer and skip_pulse is compared after each step; file registers are modelled, not compared.
// Assumes exec_pkg and exec_core are compiled first; single 100 MHz clock.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import exec_pkg::*;
    logic mclk;
    logic rst;
    logic instr_valid;
    instr_t instr;
    reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic ready;
    logic skip_pulse;
    logic [9:0] pc;
    logic [7:0] work_reg;
    logic zero_flag;
    logic global_irq_enable;
    logic [1:0] stack_ptr;
    int fails;
    int checked;
    int m_pc, m_work, m_zero, m_irq_en, m_tab_hi, m_sp, m_skip;
    int fr [64];
    int v;
    logic [5:0] fa;

    exec_core #(.STACK_DEPTH(4)) uut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
        .instr(instr), .reg_req(reg_req), .reg_rdata(reg_rdata), .ready(ready),
        .skip_pulse(skip_pulse), .pc(pc), .work_reg(work_reg), .zero_flag(zero_flag),
        .global_irq_enable(global_irq_enable), .stack_ptr(stack_ptr));

    // Free-running instruction clock
    always #5 mclk = ~mclk;

    task automatic close_out();
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cmp_all();
        chk("pc", m_pc[9:0], pc);
        chk("work_reg", {2'h0, m_work[7:0]}, {2'h0, work_reg});
        chk("zero_flag", {9'h0, m_zero[0]}, {9'h0, zero_flag});
        chk("global_irq_enable", {9'h0, m_irq_en[0]}, {9'h0, global_irq_enable});
        chk("stack_ptr", {8'h0, m_sp[1:0]}, {8'h0, stack_ptr});
        chk("skip_pulse", {9'h0, m_skip[0]}, {9'h0, skip_pulse});
    endtask : cmp_all

    // Reference behaviour; returns the number of bubble cycles
    function automatic int model(input op_t op, input int a, input logic d);
        int r;
        int bub;
        bub = 0;
        m_skip = 0;
        r = (op == OP_OR_WORK) ? ((m_work | fr[a]) & 255) : ((fr[a] + 1) & 255);
        case (op)
            OP_IRQ_ON: begin
                m_irq_en = 1;
                m_pc = m_pc + 1;
            end
            OP_JUMP_WORK: begin
                m_pc = m_tab_hi * 256 + m_work;
                bub = 1;
            end
            OP_SOFT_TRAP: begin
                m_sp = (m_sp + 1) % 4;
                m_pc = 1;
                bub = 2;
            end
            default: begin
                if (d) fr[a] = r;
                else m_work = r;
                if (op != OP_ADD_ONE_SKIP) m_zero = (r == 0);
                m_skip = (op == OP_ADD_ONE_SKIP) && (r == 0);
                bub = m_skip;
                m_pc = m_pc + 1 + m_skip;
            end
        endcase
        m_pc = m_pc & 1023;
        return bub;
    endfunction : model

    // One instruction; an OR is offered in each bubble and must be ignored
    task automatic run(input op_t op, input logic [5:0] a, input logic d);
        int bub;
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr <= '{op: op, faddr: a, dest: d};
        @(posedge mclk);
        bub = model(op, int'(a), d);
        instr <= '{op: OP_OR_WORK, faddr: a, dest: 1'b0};
        instr_valid <= (bub > 0);
        #1;
        cmp_all();
        for (int i = 1; i <= bub; i++) begin
            chk("ready", 10'h0, {9'h0, ready});
            @(posedge mclk);
            instr_valid <= (i < bub);
            #1;
            m_skip = 0;
            cmp_all();
        end
        chk("ready", 10'h1, {9'h0, ready});
    endtask : run

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge mclk);
        reg_req <= '0;
        if (a == REG_CTRL) begin
            m_irq_en = d[0];
            m_tab_hi = d[2:1];
        end
        if (a == REG_WORK) m_work = d;
    endtask : wr

    task automatic rd(input logic [1:0] a);
        logic [7:0] e;
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        e = (a == REG_CTRL) ? {5'h00, m_tab_hi[1:0], m_irq_en[0]} :
            (a == REG_STATUS) ? {6'h00, 1'b1, m_zero[0]} :
            (a == REG_WORK) ? m_work[7:0] : 8'h00;
        @(posedge mclk);
        reg_req <= '0;
        #1;
        chk("reg_rdata", {2'h0, e}, {2'h0, reg_rdata});
        cmp_all();
    endtask : rd

    // Watchdog against a hung run
    initial begin
        #500000;
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        reg_req = '0;
        void'($urandom(99));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(REG_STATUS);
        wr(2'h3, 8'h5a);
        rd(2'h3);
        wr(REG_CTRL, 8'h04);
        rd(REG_CTRL);
        run(OP_IRQ_ON, 6'h00, 1'b0);
        rd(REG_CTRL);
        for (int k = 0; k < 6; k++) begin
            fa = 6'($urandom % 64);
            v = $urandom & 255;
            wr(REG_WORK, 8'hff);
            run(OP_OR_WORK, fa, 1'b1);
            run(OP_ADD_ONE, fa, 1'b1);
            wr(REG_WORK, v[7:0]);
            run(OP_OR_WORK, fa, 1'b1);
            run(OP_OR_WORK, fa, 1'b0);
            run(OP_ADD_ONE, fa, 1'b0);
            run(OP_ADD_ONE_SKIP, fa, k[0]);
            wr(REG_WORK, 8'hff);
            run(OP_OR_WORK, fa, 1'b1);
            run(OP_ADD_ONE_SKIP, fa, ~k[0]);
            rd(REG_WORK);
            wr(REG_CTRL, {5'h00, 2'($urandom % 4), k[1]});
            wr(REG_WORK, 8'($urandom));
            run(OP_JUMP_WORK, fa, 1'b0);
            run(OP_SOFT_TRAP, fa, 1'b0);
            rd(REG_STATUS);
        end
        close_out();
    end
endmodule : tb
`default_nettype wire
